/* rtl/spd_pkg.sv */
// Package for the status pin clock divider: map, fields, resets, types
package spd_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] SPD_IDX_DIV_RATIO = 8'h2f;
	localparam logic [7:0] SPD_IDX_PIN_SOURCE = 8'h30;
	localparam logic [7:0] SPD_IDX_EDGE_RATE = 8'h31;
	localparam logic [7:0] SPD_IDX_CTRL_STAT = 8'h3f;
	localparam int SPD_ADDR_LSB = 2;
	localparam int SPD_IDX_W = 8;

	// Field positions
	localparam int SPD_FIRST_FIELD_LSB = 0;
	localparam int SPD_SECOND_FIELD_LSB = 2;
	localparam int SPD_SOFT_RESET_BIT = 0;
	localparam int SPD_LOADED_BIT = 1;
	localparam int SPD_RUNNING_BIT = 2;

	// Values after reset
	localparam logic [7:0] SPD_RATIO_RESET = 8'h00;
	localparam logic [1:0] SPD_EDGE_RESET = 2'h0;
	localparam logic [1:0] SPD_SOURCE_RESET = 2'h2;

	// Ratio coding
	localparam logic [7:0] SPD_RATIO_OFF = 8'h00;
	localparam logic [7:0] SPD_RATIO_CLAMP_MAX = 8'h05;
	localparam logic [8:0] SPD_RATIO_MIN = 9'h006;

	// Edge-rate codes
	localparam logic [1:0] SPD_EDGE_FAST = 2'h0;
	localparam logic [1:0] SPD_EDGE_SLOW = 2'h2;

	// Pin source select codes
	typedef enum logic [1:0] {
		SPD_SRC_FIRST_DIV = 2'h0,
		SPD_SRC_SECOND_DIV = 2'h1,
		SPD_SRC_STATUS = 2'h2,
		SPD_SRC_OFF = 2'h3
	} spd_source_t;

	// Configuration image as stored in non-volatile memory
	typedef struct packed {
		logic [7:0] aux_divide_ratio_b;
		logic [1:0] second_flag_pin_edge_rate;
		logic [1:0] first_flag_pin_edge_rate;
		logic [1:0] second_flag_pin_source_select;
		logic [1:0] first_flag_pin_source_select;
	} spd_cfg_t;
endpackage : spd_pkg

/* rtl/spd_status_pin_clock_divider.sv */
// Second auxiliary clock divider and status pin drive, AHB-Lite slave
//
// Overview of operation
// - Eight-bit divider clocked by synthesizer pre-divider
// - Ratio code zero disables divider output
// - Codes one to five divide by six
// - Codes six upward divide by code plus one
// - Second pin edge-rate select, fast or slow
// - First pin edge-rate select, fast or slow
// - Source code one routes divider to pin
`timescale 1ns/1ps

module spd_status_pin_clock_divider
	import spd_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic [31:0] o_hrdata,
	output logic o_hresp,
	input wire logic i_pre_div_clk,
	input wire logic i_nvm_load_valid,
	input wire spd_cfg_t i_nvm_image,
	input wire logic i_first_div_clk,
	input wire logic i_first_status,
	input wire logic i_second_status,
	output logic o_first_flag_pin,
	output logic o_first_flag_pin_en,
	output logic [1:0] o_first_flag_pin_edge_rate,
	output logic o_second_flag_pin,
	output logic o_second_flag_pin_en,
	output logic [1:0] o_second_flag_pin_edge_rate
);

	typedef enum logic {
		SPD_DIV_STOPPED,
		SPD_DIV_RUNNING
	} spd_div_state_t;

	////////////////////////////////////////////////////////////////////////
	// Bus address phase capture

	logic wr_pend;
	logic [SPD_IDX_W-1:0] wr_idx;
	logic next_wr_pend;
	logic [SPD_IDX_W-1:0] next_wr_idx;
	logic take;
	logic [SPD_IDX_W-1:0] addr_idx;

	always_comb begin
		take = i_hsel && i_htrans[1] && i_hready;
		addr_idx = i_haddr[SPD_ADDR_LSB +: SPD_IDX_W];
		next_wr_pend = take && i_hwrite;
		next_wr_idx = take ? addr_idx : wr_idx;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			wr_pend <= 1'b0;
			wr_idx <= '0;
		end else begin
			wr_pend <= next_wr_pend;
			wr_idx <= next_wr_idx;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers

	spd_cfg_t cfg;
	spd_cfg_t next_cfg;
	logic loaded;
	logic next_loaded;
	logic soft_reset;
	logic next_soft_reset;

	always_comb begin
		next_cfg = cfg;
		next_loaded = loaded;
		next_soft_reset = 1'b0;
		if (!loaded && i_nvm_load_valid) begin
			next_cfg = i_nvm_image;
			next_loaded = 1'b1;
		end else if (wr_pend) begin
			case (wr_idx)
				SPD_IDX_DIV_RATIO: begin
					next_cfg.aux_divide_ratio_b = i_hwdata[7:0];
				end
				SPD_IDX_EDGE_RATE: begin
					next_cfg.second_flag_pin_edge_rate =
						i_hwdata[SPD_SECOND_FIELD_LSB +: 2];
					next_cfg.first_flag_pin_edge_rate =
						i_hwdata[SPD_FIRST_FIELD_LSB +: 2];
				end
				SPD_IDX_PIN_SOURCE: begin
					next_cfg.second_flag_pin_source_select =
						i_hwdata[SPD_SECOND_FIELD_LSB +: 2];
					next_cfg.first_flag_pin_source_select =
						i_hwdata[SPD_FIRST_FIELD_LSB +: 2];
				end
				SPD_IDX_CTRL_STAT: begin
					next_soft_reset = i_hwdata[SPD_SOFT_RESET_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			cfg.aux_divide_ratio_b <= SPD_RATIO_RESET;
			cfg.second_flag_pin_edge_rate <= SPD_EDGE_RESET;
			cfg.first_flag_pin_edge_rate <= SPD_EDGE_RESET;
			cfg.second_flag_pin_source_select <= SPD_SOURCE_RESET;
			cfg.first_flag_pin_source_select <= SPD_SOURCE_RESET;
			loaded <= 1'b0;
			soft_reset <= 1'b0;
		end else begin
			cfg <= next_cfg;
			loaded <= next_loaded;
			soft_reset <= next_soft_reset;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Source clock synchroniser and edge enable

	logic src_meta;
	logic src_sync;
	logic src_last;
	logic src_tick;

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			src_meta <= 1'b0;
			src_sync <= 1'b0;
			src_last <= 1'b0;
		end else begin
			src_meta <= i_pre_div_clk;
			src_sync <= src_meta;
			src_last <= src_sync;
		end
	end

	assign src_tick = src_sync && !src_last;

	////////////////////////////////////////////////////////////////////////
	// Divider

	spd_div_state_t div_state;
	spd_div_state_t next_div_state;
	logic [7:0] div_count;
	logic [7:0] next_div_count;
	logic div_clk;
	logic next_div_clk;
	logic [8:0] ratio;
	logic [8:0] last_count;
	logic [8:0] half;
	logic ratio_off;

	always_comb begin
		ratio_off = (cfg.aux_divide_ratio_b == SPD_RATIO_OFF);
		if (cfg.aux_divide_ratio_b <= SPD_RATIO_CLAMP_MAX) begin
			ratio = SPD_RATIO_MIN;
		end else begin
			ratio = {1'b0, cfg.aux_divide_ratio_b} + 9'h001;
		end
		last_count = ratio - 9'h001;
		half = ratio >> 1;
		next_div_state = div_state;
		next_div_count = div_count;
		next_div_clk = div_clk;
		case (div_state)
			SPD_DIV_STOPPED: begin
				next_div_clk = 1'b0;
				next_div_count = '0;
				if ((soft_reset && !ratio_off) || (!loaded &&
					i_nvm_load_valid &&
					i_nvm_image.aux_divide_ratio_b != SPD_RATIO_OFF)) begin
					next_div_state = SPD_DIV_RUNNING;
				end
			end
			SPD_DIV_RUNNING: begin
				if (ratio_off) begin
					next_div_state = SPD_DIV_STOPPED;
					next_div_clk = 1'b0;
					next_div_count = '0;
				end else if (soft_reset) begin
					next_div_count = '0;
					next_div_clk = 1'b1;
				end else if (src_tick) begin
					if ({1'b0, div_count} >= last_count) begin
						next_div_count = '0;
					end else begin
						next_div_count = div_count + 8'h01;
					end
					next_div_clk = ({1'b0, next_div_count} < half);
				end
			end
			default: begin
				next_div_state = SPD_DIV_STOPPED;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			div_state <= SPD_DIV_STOPPED;
			div_count <= '0;
			div_clk <= 1'b0;
		end else begin
			div_state <= next_div_state;
			div_count <= next_div_count;
			div_clk <= next_div_clk;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status pin drive

	logic next_first_pin;
	logic next_first_en;
	logic next_second_pin;
	logic next_second_en;

	function automatic logic [1:0] spd_pick(input logic [1:0] sel,
		input logic first_clk, input logic second_clk,
		input logic status);
		logic [1:0] r;
		r = 2'b00;
		case (sel)
			SPD_SRC_FIRST_DIV: r = {first_clk, 1'b1};
			SPD_SRC_SECOND_DIV: r = {second_clk, 1'b1};
			SPD_SRC_STATUS: r = {status, 1'b1};
			default: r = 2'b00;
		endcase
		return r;
	endfunction : spd_pick

	always_comb begin
		{next_first_pin, next_first_en} = spd_pick(
			cfg.first_flag_pin_source_select, i_first_div_clk,
			next_div_clk, i_first_status);
		{next_second_pin, next_second_en} = spd_pick(
			cfg.second_flag_pin_source_select, i_first_div_clk,
			next_div_clk, i_second_status);
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_first_flag_pin <= 1'b0;
			o_first_flag_pin_en <= 1'b0;
			o_second_flag_pin <= 1'b0;
			o_second_flag_pin_en <= 1'b0;
			o_first_flag_pin_edge_rate <= SPD_EDGE_RESET;
			o_second_flag_pin_edge_rate <= SPD_EDGE_RESET;
		end else begin
			o_first_flag_pin <= next_first_pin;
			o_first_flag_pin_en <= next_first_en;
			o_second_flag_pin <= next_second_pin;
			o_second_flag_pin_en <= next_second_en;
			o_first_flag_pin_edge_rate <=
				next_cfg.first_flag_pin_edge_rate;
			o_second_flag_pin_edge_rate <=
				next_cfg.second_flag_pin_edge_rate;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, taken from next values so a read after a write is current

	logic [31:0] next_hrdata;

	always_comb begin
		next_hrdata = o_hrdata;
		if (take && !i_hwrite) begin
			next_hrdata = '0;
			case (addr_idx)
				SPD_IDX_DIV_RATIO: begin
					next_hrdata[7:0] = next_cfg.aux_divide_ratio_b;
				end
				SPD_IDX_EDGE_RATE: begin
					next_hrdata[SPD_SECOND_FIELD_LSB +: 2] =
						next_cfg.second_flag_pin_edge_rate;
					next_hrdata[SPD_FIRST_FIELD_LSB +: 2] =
						next_cfg.first_flag_pin_edge_rate;
				end
				SPD_IDX_PIN_SOURCE: begin
					next_hrdata[SPD_SECOND_FIELD_LSB +: 2] =
						next_cfg.second_flag_pin_source_select;
					next_hrdata[SPD_FIRST_FIELD_LSB +: 2] =
						next_cfg.first_flag_pin_source_select;
				end
				SPD_IDX_CTRL_STAT: begin
					next_hrdata[SPD_LOADED_BIT] = next_loaded;
					next_hrdata[SPD_RUNNING_BIT] =
						(next_div_state == SPD_DIV_RUNNING);
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_hrdata <= '0;
			o_hreadyout <= 1'b0;
			o_hresp <= 1'b0;
		end else begin
			o_hrdata <= next_hrdata;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end
	end

endmodule : spd_status_pin_clock_divider

/* test/spd_status_pin_clock_divider_properties.sv */
// Assertions on the status pin clock divider ports
`timescale 1ns/1ps
module spd_status_pin_clock_divider_properties
	import spd_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_hsel,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic i_hready,
	input wire logic i_nvm_load_valid,
	input wire spd_cfg_t i_nvm_image,
	input wire logic o_hreadyout,
	input wire logic [31:0] o_hrdata,
	input wire logic o_hresp,
	input wire logic [1:0] o_first_flag_pin_edge_rate,
	input wire logic [1:0] o_second_flag_pin_edge_rate
);
	logic [3:0] recent, next_recent;
	logic ld, next_ld;
	spd_cfg_t cap, next_cap;
	wire logic take = i_hsel & i_htrans[1] & i_hready;
	always_comb begin
		next_recent = {recent[2:0], (take & i_hwrite) | i_nvm_load_valid};
		next_ld = i_reset_n & (ld | i_nvm_load_valid);
		next_cap = (i_nvm_load_valid & !ld) ? i_nvm_image : cap;
	end
	always_ff @(posedge i_mclk) begin
		recent <= next_recent;
		ld <= next_ld;
		cap <= next_cap;
	end
	////////////////////////////////////////////////////////////
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	sequence s_loaded;
		$rose(ld);
	endsequence
	a_resp_okay: assert property (o_hresp == 1'b0)
		else $error("error response");
	a_ready_no_wait: assert property ($past(i_reset_n) |-> o_hreadyout)
		else $error("wait state inserted");
	a_reset_clears: assert property (disable iff (1'b0)
		!i_reset_n |=> o_first_flag_pin_edge_rate == 2'h0 &&
		o_second_flag_pin_edge_rate == 2'h0 && !o_hreadyout)
		else $error("outputs not cleared by reset");
	a_rdata_cause: assert property ($changed(o_hrdata) |-> $past(take))
		else $error("read data moved without a read");
	a_rdata_upper: assert property (o_hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_second_edge_held: assert property (
		$changed(o_second_flag_pin_edge_rate) |-> |recent)
		else $error("second edge rate moved alone");
	a_first_edge_held: assert property (
		$changed(o_first_flag_pin_edge_rate) |-> |recent)
		else $error("first edge rate moved alone");
	a_nvm_edge_load: assert property (s_loaded |-> ##[0:2]
		(o_second_flag_pin_edge_rate == cap.second_flag_pin_edge_rate &&
		o_first_flag_pin_edge_rate == cap.first_flag_pin_edge_rate))
		else $error("edge rates not loaded");
endmodule : spd_status_pin_clock_divider_properties

bind spd_status_pin_clock_divider spd_status_pin_clock_divider_properties
	spd_status_pin_clock_divider_properties_inst (.*);

/* test/spd_status_pin_clock_divider_tb.sv */
// Self-checking bench for the status pin clock divider
`timescale 1ns/1ps
module spd_status_pin_clock_divider_tb
	import spd_pkg::*;
;
	logic i_mclk = 0, i_reset_n = 0, i_hsel = 0, i_hwrite = 0;
	logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata;
	logic [1:0] i_htrans = 0, o_first_flag_pin_edge_rate;
	logic [1:0] o_second_flag_pin_edge_rate, div_cnt = 0;
	logic i_pre_div_clk = 0, i_nvm_load_valid = 0;
	logic i_first_div_clk = 0, i_first_status = 0, i_second_status = 0;
	spd_cfg_t i_nvm_image = '0;
	logic o_hreadyout, o_hresp, o_first_flag_pin, o_first_flag_pin_en;
	logic o_second_flag_pin, o_second_flag_pin_en;
	int miscompares = 0, comparisons = 0, cycles = 0, src_edges = 0;
	spd_status_pin_clock_divider spd_status_pin_clock_divider_inst (
		.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_hsel(i_hsel),
		.i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
		.i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
		.o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp),
		.i_pre_div_clk(i_pre_div_clk), .i_nvm_load_valid(i_nvm_load_valid),
		.i_nvm_image(i_nvm_image), .i_first_div_clk(i_first_div_clk),
		.i_first_status(i_first_status),
		.i_second_status(i_second_status),
		.o_first_flag_pin(o_first_flag_pin),
		.o_first_flag_pin_en(o_first_flag_pin_en),
		.o_first_flag_pin_edge_rate(o_first_flag_pin_edge_rate),
		.o_second_flag_pin(o_second_flag_pin),
		.o_second_flag_pin_en(o_second_flag_pin_en),
		.o_second_flag_pin_edge_rate(o_second_flag_pin_edge_rate));
	always #5 i_mclk = ~i_mclk;
	// Source clock at one eighth of the bus clock; hang guard
	always @(posedge i_mclk) begin
		div_cnt <= div_cnt + 2'h1;
		if (div_cnt == 2'h3) begin
			i_pre_div_clk <= ~i_pre_div_clk;
			src_edges <= src_edges + (i_pre_div_clk ? 0 : 1);
		end
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			miscompares = miscompares + 1;
			results();
		end
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic [7:0] idx, input logic w,
		input logic [31:0] wd, output logic [31:0] rdv);
		i_hsel <= 1'b1;
		i_htrans <= 2'h2;
		i_haddr <= {22'h0, idx, 2'h0};
		i_hwrite <= w;
		@(posedge i_mclk);
		while (o_hreadyout !== 1'b1) @(posedge i_mclk);
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= wd;
		@(posedge i_mclk);
		while (o_hreadyout !== 1'b1) @(posedge i_mclk);
		rdv = o_hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] x;
		bus(idx, 1'b1, d, x);
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [31:0] e);
		logic [31:0] x;
		bus(idx, 1'b0, 32'h0, x);
		chk(x, e);
	endtask : rd
	task automatic wait_pin(input logic first, input logic v);
		while ((first ? o_first_flag_pin : o_second_flag_pin) !== v) begin
			@(posedge i_mclk);
		end
	endtask : wait_pin
	////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(8'h2f, 32'h0);
		rd(8'h30, 32'ha);
		rd(8'h31, 32'h0);
		rd(8'h3f, 32'h0);
		rd(8'h10, 32'h0);
		$display("reset values done");
	endtask : t_reset
	task automatic t_nvm;
		i_nvm_image <= 16'h0787;
		i_nvm_load_valid <= 1'b1;
		@(posedge i_mclk);
		i_nvm_load_valid <= 1'b0;
		i_nvm_image <= 16'h0920;
		@(posedge i_mclk);
		i_nvm_load_valid <= 1'b1;
		@(posedge i_mclk);
		i_nvm_load_valid <= 1'b0;
		repeat (3) @(posedge i_mclk);
		chk(o_second_flag_pin_edge_rate, 32'h2);
		chk(o_first_flag_pin_en, 1'b0);
		chk(o_second_flag_pin_en, 1'b1);
		rd(8'h2f, 32'h7);
		rd(8'h31, 32'h8);
		rd(8'h3f, 32'h6);
		$display("start-up load done");
	endtask : t_nvm
	task automatic t_edge;
		for (int c = 0; c < 4; c++) begin
			wr(8'h31, 32'hf0 | (c << 2) | (c & 2));
			repeat (2) @(posedge i_mclk);
			chk(o_second_flag_pin_edge_rate, c);
			chk(o_first_flag_pin_edge_rate, c & 2);
			rd(8'h31, (c << 2) | (c & 2));
		end
		$display("edge rate done");
	endtask : t_edge
	task automatic t_div;
		int n;
		int t0;
		logic [7:0] codes [5] = '{8'h01, 8'h05, 8'h06, 8'h07, 8'hff};
		foreach (codes[i]) begin
			n = (codes[i] < 6) ? 6 : codes[i] + 1;
			wr(8'h2f, {24'h0, codes[i]});
			wr(8'h3f, 32'h1);
			repeat (2) @(posedge i_mclk);
			chk(o_second_flag_pin, 1'b1);
			wait_pin(1'b0, 1'b0);
			wait_pin(1'b0, 1'b1);
			t0 = src_edges;
			wait_pin(1'b0, 1'b0);
			chk(src_edges - t0, n / 2);
			wait_pin(1'b0, 1'b1);
			chk(src_edges - t0, n);
		end
		$display("divide ratios done");
	endtask : t_div
	task automatic t_off;
		wr(8'h2f, 32'h0);
		repeat (20) @(posedge i_mclk);
		chk(o_second_flag_pin, 1'b0);
		wr(8'h2f, 32'h6);
		repeat (100) @(posedge i_mclk);
		chk(o_second_flag_pin, 1'b0);
		rd(8'h3f, 32'h2);
		wr(8'h3f, 32'h1);
		rd(8'h3f, 32'h6);
		$display("disable done");
	endtask : t_off
	task automatic t_src;
		int t0;
		wr(8'h30, 32'h6);
		i_first_status <= 1'b1;
		repeat (3) @(posedge i_mclk);
		chk({o_first_flag_pin, o_first_flag_pin_en}, 32'h3);
		chk(o_second_flag_pin_en, 1'b1);
		wr(8'h30, 32'h8);
		i_second_status <= 1'b1;
		i_first_div_clk <= 1'b1;
		repeat (3) @(posedge i_mclk);
		chk({o_first_flag_pin, o_first_flag_pin_en}, 32'h3);
		chk({o_second_flag_pin, o_second_flag_pin_en}, 32'h3);
		wr(8'h30, 32'hf);
		repeat (3) @(posedge i_mclk);
		chk({o_first_flag_pin, o_first_flag_pin_en}, 32'h0);
		chk({o_second_flag_pin, o_second_flag_pin_en}, 32'h0);
		rd(8'h30, 32'hf);
		wr(8'h30, 32'h5);
		i_first_status <= 1'b0;
		i_second_status <= 1'b0;
		i_first_div_clk <= 1'b0;
		wait_pin(1'b1, 1'b1);
		wait_pin(1'b1, 1'b0);
		wait_pin(1'b1, 1'b1);
		t0 = src_edges;
		wait_pin(1'b1, 1'b0);
		chk(src_edges - t0, 32'h3);
		wait_pin(1'b1, 1'b1);
		chk(src_edges - t0, 32'h7);
		chk(o_second_flag_pin_en, 1'b1);
		$display("pin source done");
	endtask : t_src
	task automatic t_rerun;
		i_reset_n <= 1'b0;
		repeat (5) @(posedge i_mclk);
		chk(o_hreadyout, 1'b0);
		chk(o_second_flag_pin_edge_rate, 32'h0);
		chk(o_first_flag_pin_edge_rate, 32'h0);
		i_reset_n <= 1'b1;
		repeat (2) @(posedge i_mclk);
		chk(o_first_flag_pin_en, 1'b1);
		t_reset();
		$display("second reset done");
	endtask : t_rerun
	task automatic results;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results
	initial begin
		repeat (5) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		repeat (2) @(posedge i_mclk);
		t_reset();
		t_nvm();
		t_edge();
		t_div();
		t_off();
		t_src();
		t_rerun();
		results();
	end
endmodule : spd_status_pin_clock_divider_tb
